// ==== rtl/mct_pkg.sv ====
// Shared constants and types for the machine-cycle timer/counter block.
// Assumes a single clock that is the oscillator and an AXI4-Lite register bus.
package mct_pkg;

	// Bus geometry; a register's byte address is four times its index.
	localparam int         AXI_AW   = 12;
	localparam int         IDX_LSB  = 2;
	localparam int         IDX_MSB  = 9;
	localparam logic [1:0] ADDR_TOP = 2'h0;

	// Register indexes.
	localparam logic [7:0] IDX_CLOCK = 8'h87;
	localparam logic [7:0] IDX_RUN   = 8'h88;
	localparam logic [7:0] IDX_MODE  = 8'h89;
	localparam logic [7:0] IDX_U0_LO = 8'h8A;
	localparam logic [7:0] IDX_U1_LO = 8'h8B;
	localparam logic [7:0] IDX_U0_HI = 8'h8C;
	localparam logic [7:0] IDX_U1_HI = 8'h8D;
	localparam logic [7:0] IDX_STAT  = 8'h90;
	localparam logic [7:0] IDX_MASK  = 8'h91;

	// Reset values.
	localparam logic [7:0] MODE_RST  = 8'h00;
	localparam logic [7:0] BYTE_RST  = 8'h00;
	localparam logic [1:0] PAIR_RST  = 2'h0;

	// Field positions inside the run, clock and status registers.
	localparam int RUN_U0   = 0;
	localparam int RUN_U1   = 1;
	localparam int CLK_SEL  = 0;
	localparam int CLK_FAST = 1;
	localparam int OVF_U0   = 0;
	localparam int OVF_U1   = 1;

	// Oscillator periods per machine cycle.
	localparam logic [3:0] MC_SLOW = 4'hC;
	localparam logic [3:0] MC_FAST = 4'h6;
	localparam logic [3:0] MC_ONE  = 4'h1;
	localparam logic [3:0] MC_ZERO = 4'h0;

	// Width of the prescaler part of the 13-bit mode.
	localparam int PRE_W = 5;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MCT_M13   = 2'h0,
		MCT_M16   = 2'h1,
		MCT_M8R   = 2'h2,
		MCT_SPLIT = 2'h3
	} mct_mode_t;

	// One unit's nibble of the mode register, top bit first.
	typedef struct packed {
		logic      gate;
		logic      cnt_sel;
		mct_mode_t mode;
	} mct_user_config_fuses_t;

	typedef struct packed {
		mct_user_config_fuses_t u1;
		mct_user_config_fuses_t u0;
	} mct_timer_mode_control_t;

	typedef enum logic [1:0] {
		MCT_W_IDLE = 2'b01,
		MCT_W_RESP = 2'b10
	} mct_wst_t;

	typedef enum logic [1:0] {
		MCT_R_IDLE = 2'b01,
		MCT_R_DATA = 2'b10
	} mct_rst_t;

endpackage : mct_pkg

// ==== rtl/mct_unit.sv ====
// One 16-bit timer/counter unit made of a low and a high byte.
// Assumes increment pulses already qualified by machine cycle and run, and the low byte's also by gate.
`timescale 1ns/1ns
module mct_unit
	import mct_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire mct_mode_t  mode,
	input  wire logic       inc_lo,
	input  wire logic       inc_hi,
	input  wire logic       wr_lo,
	input  wire logic       wr_hi,
	input  wire logic [7:0] wbyte,
	output logic      [7:0] lo_q,
	output logic      [7:0] hi_q,
	output logic            ovf_lo,
	output logic            ovf_hi
);

	logic [7:0] lo_r;
	logic [7:0] hi_r;
	logic [7:0] lo_nxt;
	logic [7:0] hi_nxt;
	logic       ovl;
	logic       ovh;

	// Carries out of each byte and of the prescaler.
	wire  [8:0]       lo_sum  = {1'b0, lo_r} + 9'h001;
	wire  [8:0]       hi_sum  = {1'b0, hi_r} + 9'h001;
	wire  [PRE_W:0]   pre_sum = {1'b0, lo_r[PRE_W-1:0]} + 6'h01;

	// Next count per mode; a software write wins over a same-cycle increment.
	always_comb begin
		lo_nxt = lo_r;
		hi_nxt = hi_r;
		ovl    = 1'b0;
		ovh    = 1'b0;
		unique case (mode)
			MCT_M13: begin
				if (inc_lo) begin
					lo_nxt = {lo_r[7:PRE_W], pre_sum[PRE_W-1:0]};
					if (pre_sum[PRE_W]) begin
						hi_nxt = hi_sum[7:0];
						ovl    = hi_sum[8];
					end
				end
			end
			MCT_M16: begin
				if (inc_lo) begin
					lo_nxt = lo_sum[7:0];
					if (lo_sum[8]) begin
						hi_nxt = hi_sum[7:0];
						ovl    = hi_sum[8];
					end
				end
			end
			MCT_M8R: begin
				if (inc_lo) begin
					// The reload source is left untouched.
					if (lo_sum[8]) begin
						lo_nxt = hi_r;
						ovl    = 1'b1;
					end else begin
						lo_nxt = lo_sum[7:0];
					end
				end
			end
			MCT_SPLIT: begin
				if (inc_lo) begin
					lo_nxt = lo_sum[7:0];
					ovl    = lo_sum[8];
				end
				if (inc_hi) begin
					hi_nxt = hi_sum[7:0];
					ovh    = hi_sum[8];
				end
			end
		endcase
		if (wr_lo) begin
			lo_nxt = wbyte;
		end
		if (wr_hi) begin
			hi_nxt = wbyte;
		end
	end

	// Count bytes.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lo_r <= BYTE_RST;
			hi_r <= BYTE_RST;
		end else begin
			lo_r <= lo_nxt;
			hi_r <= hi_nxt;
		end
	end

	// The low overflow pulse is dropped on a write to either byte, the high one on a high-byte write.
	assign ovf_lo = ovl & ~(wr_lo | wr_hi);
	assign ovf_hi = ovh & ~wr_hi;
	assign lo_q   = lo_r;
	assign hi_q   = hi_r;

endmodule : mct_unit

// ==== rtl/mct_top.sv ====
// Two machine-cycle timer/counters behind an AXI4-Lite slave.
// Assumes clk is the oscillator; pins and the fuse level arrive asynchronously.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
module mct_top
	import mct_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              fast_clock_fuse,
	input  wire logic              count_input_zero,
	input  wire logic              count_input_one,
	input  wire logic              external_interrupt_zero,
	input  wire logic              external_interrupt_one,
	output logic                   irq
);

	localparam int NPIN = 5;

	// Software-visible state.
	mct_timer_mode_control_t  timer_mode_control_r;
	logic [1:0] run_r;
	logic       fast_sel_r;
	logic [1:0] stat_r;
	logic [1:0] mask_r;
	logic [1:0] stat_nxt;

	// Pin synchronisers, bit order {fuse, int1, external_interrupt_zero, cin1, cin0}.
	wire  [NPIN-1:0] pin_a = {fast_clock_fuse, external_interrupt_one,
		external_interrupt_zero, count_input_one, count_input_zero};
	logic [NPIN-1:0] meta_r;
	logic [NPIN-1:0] sync_r;

	// Each pin passes two flops; only the second is read by logic.
	genvar gp;
	generate
		for (gp = 0; gp < NPIN; gp++) begin : g_sync
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					meta_r[gp] <= 1'b0;
					sync_r[gp] <= 1'b0;
				end else begin
					meta_r[gp] <= pin_a[gp];
					sync_r[gp] <= meta_r[gp];
				end
			end
		end
	endgenerate

	wire [1:0] cin_s = sync_r[1:0];
	wire [1:0] int_s = sync_r[3:2];
	wire       fuse_s = sync_r[4];

	// Machine-cycle divider. The fuse overrides the select bit.
	wire       fast_mode = fuse_s | fast_sel_r;
	wire [3:0] mc_len    = fast_mode ? MC_FAST : MC_SLOW;
	wire [3:0] mc_last   = mc_len - MC_ONE;
	logic [3:0] mc_cnt_r;
	// Using >= lets a switch from twelve to six mid-cycle recover at once.
	wire       mc_tick   = (mc_cnt_r >= mc_last);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mc_cnt_r <= MC_ZERO;
		end else begin
			mc_cnt_r <= mc_tick ? MC_ZERO : mc_cnt_r + MC_ONE;
		end
	end

	// Per-unit configuration, pin sampling and increment qualification.
	mct_user_config_fuses_t cfg [2];
	assign cfg[0] = timer_mode_control_r.u0;
	assign cfg[1] = timer_mode_control_r.u1;

	logic [1:0] samp_r;
	logic [1:0] prev_r;
	logic [1:0] inc;

	genvar gu;
	generate
		for (gu = 0; gu < 2; gu++) begin : g_unit
			// Samples shift once per machine cycle, so a fall needs two cycles.
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					samp_r[gu] <= 1'b0;
					prev_r[gu] <= 1'b0;
				end else if (mc_tick) begin
					samp_r[gu] <= cin_s[gu];
					prev_r[gu] <= samp_r[gu];
				end
			end
			// The increment lands at the tick that ends the next machine cycle.
			wire fall = prev_r[gu] & ~samp_r[gu];
			wire en   = run_r[gu] & (~cfg[gu].gate | int_s[gu]);
			wire src  = cfg[gu].cnt_sel ? fall : 1'b1;
			assign inc[gu] = mc_tick & en & src;
		end
	endgenerate

	// Split and stop decisions for mode 3.
	wire u0_split = (cfg[0].mode == MCT_SPLIT);
	wire u1_stop  = (cfg[1].mode == MCT_SPLIT);
	wire u0_hi_inc = mc_tick & run_r[RUN_U1];
	wire u1_lo_inc = inc[1] & ~u1_stop;

	// Write channel.
	mct_wst_t          wst_r;
	logic              aw_hold_r;
	logic              w_hold_r;
	logic [AXI_AW-1:0] awaddr_r;
	logic [31:0]       wdata_r;
	logic [3:0]        wstrb_r;
	logic [1:0]        bresp_r;

	assign s_axi_awready = ~aw_hold_r & (wst_r == MCT_W_IDLE);
	assign s_axi_wready  = ~w_hold_r & (wst_r == MCT_W_IDLE);
	assign s_axi_bvalid  = (wst_r == MCT_W_RESP);
	assign s_axi_bresp   = bresp_r;

	wire aw_fire = s_axi_awvalid & s_axi_awready;
	wire w_fire  = s_axi_wvalid & s_axi_wready;
	wire wr_go   = (aw_hold_r | aw_fire) & (w_hold_r | w_fire) & (wst_r == MCT_W_IDLE);

	// Address and data in either order; a held copy is used once taken.
	wire [AXI_AW-1:0] waddr = aw_hold_r ? awaddr_r : s_axi_awaddr;
	wire [31:0]       wdat  = w_hold_r ? wdata_r : s_axi_wdata;
	wire [3:0]        wstb  = w_hold_r ? wstrb_r : s_axi_wstrb;
	wire [7:0]        widx  = waddr[IDX_MSB:IDX_LSB];
	wire              wtop  = (waddr[AXI_AW-1:IDX_MSB+1] == ADDR_TOP);
	wire              wbyte = wr_go & wstb[0] & wtop;
	wire [7:0]        wb    = wdat[7:0];

	wire we_clock = wbyte & (widx == IDX_CLOCK);
	wire we_run   = wbyte & (widx == IDX_RUN);
	wire we_mode  = wbyte & (widx == IDX_MODE);
	wire we_u0lo  = wbyte & (widx == IDX_U0_LO);
	wire we_u1lo  = wbyte & (widx == IDX_U1_LO);
	wire we_u0hi  = wbyte & (widx == IDX_U0_HI);
	wire we_u1hi  = wbyte & (widx == IDX_U1_HI);
	wire we_mask  = wbyte & (widx == IDX_MASK);

	// Status is writable only by hardware, so a write to it is accepted and ignored.
	wire w_mapped = wtop & ((widx == IDX_CLOCK) | (widx == IDX_RUN) |
		(widx == IDX_MODE) | (widx == IDX_U0_LO) | (widx == IDX_U1_LO) |
		(widx == IDX_U0_HI) | (widx == IDX_U1_HI) | (widx == IDX_STAT) |
		(widx == IDX_MASK));

	// Write handshake state.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wst_r     <= MCT_W_IDLE;
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= '0;
			wstrb_r   <= '0;
			bresp_r   <= RESP_OKAY;
		end else begin
			if (aw_fire & ~wr_go) begin
				aw_hold_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (w_fire & ~wr_go) begin
				w_hold_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				wst_r     <= MCT_W_RESP;
				bresp_r   <= w_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if ((wst_r == MCT_W_RESP) & s_axi_bready) begin
				wst_r <= MCT_W_IDLE;
			end
		end
	end

	// Control registers; the mode register clears on reset.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_mode_control_r     <= mct_timer_mode_control_t'(MODE_RST);
			run_r      <= PAIR_RST;
			fast_sel_r <= 1'b0;
			mask_r     <= PAIR_RST;
		end else begin
			if (we_mode) begin
				timer_mode_control_r <= mct_timer_mode_control_t'(wb);
			end
			if (we_run) begin
				run_r <= {wb[RUN_U1], wb[RUN_U0]};
			end
			if (we_clock) begin
				fast_sel_r <= wb[CLK_SEL];
			end
			if (we_mask) begin
				mask_r <= {wb[OVF_U1], wb[OVF_U0]};
			end
		end
	end

	// Counting units.
	wire [7:0] u0_lo;
	wire [7:0] u0_hi;
	wire [7:0] u1_lo;
	wire [7:0] u1_hi;
	wire       u0_ovl;
	wire       u0_ovh;
	wire       u1_ovl;

	mct_unit u_unit0 (
		.clk    (clk),
		.rst_b  (rst_b),
		.mode   (cfg[0].mode),
		.inc_lo (inc[0]),
		.inc_hi (u0_hi_inc),
		.wr_lo  (we_u0lo),
		.wr_hi  (we_u0hi),
		.wbyte  (wb),
		.lo_q   (u0_lo),
		.hi_q   (u0_hi),
		.ovf_lo (u0_ovl),
		.ovf_hi (u0_ovh)
	);

	mct_unit u_unit1 (
		.clk    (clk),
		.rst_b  (rst_b),
		.mode   (cfg[1].mode),
		.inc_lo (u1_lo_inc),
		.inc_hi (1'b0),
		.wr_lo  (we_u1lo),
		.wr_hi  (we_u1hi),
		.wbyte  (wb),
		.lo_q   (u1_lo),
		.hi_q   (u1_hi),
		.ovf_lo (u1_ovl),
		.ovf_hi ()
	);

	// With unit 0 split, its high byte owns unit 1's flag and unit 1 sets none.
	wire [1:0] ovf_set = {u0_split ? u0_ovh : u1_ovl, u0_ovl};

	// Read channel.
	mct_rst_t    rst_st_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;

	assign s_axi_arready = (rst_st_r == MCT_R_IDLE);
	assign s_axi_rvalid  = (rst_st_r == MCT_R_DATA);
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	wire       ar_fire = s_axi_arvalid & s_axi_arready;
	wire [7:0] ridx    = s_axi_araddr[IDX_MSB:IDX_LSB];
	wire       rtop    = (s_axi_araddr[AXI_AW-1:IDX_MSB+1] == ADDR_TOP);
	wire [7:0] clk_rd  = {6'h00, fast_mode, fast_sel_r};

	// Read selection; anything unmapped reads zero with an error answer.
	wire       r_hit_stat = rtop & (ridx == IDX_STAT);
	wire [7:0] rbyte =
		!rtop              ? 8'h00 :
		(ridx == IDX_CLOCK) ? clk_rd :
		(ridx == IDX_RUN)   ? {6'h00, run_r} :
		(ridx == IDX_MODE)  ? timer_mode_control_r :
		(ridx == IDX_U0_LO) ? u0_lo :
		(ridx == IDX_U1_LO) ? u1_lo :
		(ridx == IDX_U0_HI) ? u0_hi :
		(ridx == IDX_U1_HI) ? u1_hi :
		(ridx == IDX_STAT)  ? {6'h00, stat_r} :
		(ridx == IDX_MASK)  ? {6'h00, mask_r} : 8'h00;
	wire r_mapped = rtop & ((ridx == IDX_CLOCK) | (ridx == IDX_RUN) |
		(ridx == IDX_MODE) | (ridx == IDX_U0_LO) | (ridx == IDX_U1_LO) |
		(ridx == IDX_U0_HI) | (ridx == IDX_U1_HI) | (ridx == IDX_STAT) |
		(ridx == IDX_MASK));

	// Read handshake state; data is captured at the address handshake.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_st_r <= MCT_R_IDLE;
			rdata_r  <= '0;
			rresp_r  <= RESP_OKAY;
		end else if (ar_fire) begin
			rst_st_r <= MCT_R_DATA;
			rdata_r  <= {24'h000000, rbyte};
			rresp_r  <= r_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid & s_axi_rready) begin
			rst_st_r <= MCT_R_IDLE;
		end
	end

	// Sticky overflow status; a read clears it, but a same-cycle set survives.
	assign stat_nxt = (stat_r & ~{2{ar_fire & r_hit_stat}}) | ovf_set;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_r <= PAIR_RST;
		end else begin
			stat_r <= stat_nxt;
		end
	end

	// Level interrupt while any unmasked flag stands.
	assign irq = |(stat_r & mask_r);

endmodule : mct_top

// ==== tb/mct_pin_src.sv ====
// Model of an outside event source wired to one count input pin.
// Assumes the bench calls its task right after a rising clock edge.
`timescale 1ns/1ns
module mct_pin_src (
	input  wire logic clk,
	output logic      pin
);
	// Idles high, so the first low level is a genuine fall.
	initial pin = 1'b1;

	// Makes n falls; each level stands hold clocks, which must cover a machine cycle.
	task automatic falls(input int n, input int hold);
		repeat (n) begin
			repeat (hold) @(posedge clk);
			pin <= 1'b0;
			repeat (hold) @(posedge clk);
			pin <= 1'b1;
		end
	endtask : falls
endmodule : mct_pin_src

// ==== tb/mct_asserts.sv ====
// Checker on the register bus and interrupt ports of the timer block.
// Assumes it is bound into mct_top and sees only that module's ports.
`timescale 1ns/1ns
module mct_chk
	import mct_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst_b,
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic              irq
);
	wire logic [7:0]        ar_idx = s_axi_araddr[IDX_MSB:IDX_LSB];
	wire logic              ar_go  = s_axi_arvalid && s_axi_arready;
	wire logic [AXI_AW-1:0] mode_a = {ADDR_TOP, IDX_MODE, 2'h0};
	wire logic              ar_map = ar_idx inside {IDX_CLOCK, IDX_RUN, IDX_MODE, IDX_U0_LO,
		IDX_U1_LO, IDX_U0_HI, IDX_U1_HI, IDX_STAT, IDX_MASK};
	logic                   ar_mode_r;
	logic                   mode_wr_r;

	// Tracks the pending read target; any mode write ends the reset-value check.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ar_mode_r <= 1'b0;
			mode_wr_r <= 1'b0;
		end else begin
			if (ar_go) ar_mode_r <= (s_axi_araddr == mode_a);
			if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == mode_a) mode_wr_r <= 1'b1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |=> s_axi_bvalid) else $error("write response late");
	a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_rd_answer: assert property (ar_go |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data late");
	a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
	a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_rd_unmapped: assert property (ar_go && !ar_map |=> s_axi_rresp == RESP_SLVERR &&
		s_axi_rdata == 32'h0) else $error("unmapped read not refused");
	a_mode_reset: assert property (s_axi_rvalid && ar_mode_r && !mode_wr_r |->
		s_axi_rdata[7:0] == MODE_RST) else $error("mode register not cleared by reset");
	a_irq_reset: assert property (!$past(rst_b) |-> !irq)
		else $error("interrupt high after reset");

	c_irq: cover property ($rose(irq));
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	c_mode_rd: cover property (s_axi_rvalid && ar_mode_r);
endmodule : mct_chk

bind mct_top mct_chk u_chk (.*);

// ==== tb/tb_top.sv ====
// Self-checking bench: register bus tasks and timer/counter scenarios.
// Assumes mct_top, its package, the pin source model and the bound checker.
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top
	import mct_pkg::*;
;
	logic              clk = 1'b0;
	logic              rst_b = 1'b0;
	logic [AXI_AW-1:0] s_axi_awaddr = '0;
	logic [2:0]        s_axi_awprot = 3'h0;
	logic              s_axi_awvalid = 1'b0;
	logic [31:0]       s_axi_wdata = 32'h0;
	logic [3:0]        s_axi_wstrb = 4'h0;
	logic              s_axi_wvalid = 1'b0;
	logic              s_axi_bready = 1'b1;
	logic [AXI_AW-1:0] s_axi_araddr = '0;
	logic [2:0]        s_axi_arprot = 3'h0;
	logic              s_axi_arvalid = 1'b0;
	logic              s_axi_rready = 1'b1;
	logic              fast_clock_fuse = 1'b0;
	logic              external_interrupt_zero = 1'b0;
	logic              external_interrupt_one = 1'b0;
	wire logic         count_input_zero;
	wire logic         count_input_one;
	logic              s_axi_awready;
	logic              s_axi_wready;
	logic [1:0]        s_axi_bresp;
	logic              s_axi_bvalid;
	logic              s_axi_arready;
	logic [31:0]       s_axi_rdata;
	logic [1:0]        s_axi_rresp;
	logic              s_axi_rvalid;
	logic              irq;
	logic [31:0]       d;
	logic [1:0]        rr;
	int                k;
	int                failures = 0;
	int                samples_checked = 0;

	// Oscillator at 25 MHz.
	initial begin
		forever #20 clk = ~clk;
	end

	mct_top uut (.*);
	mct_pin_src src0 (.clk(clk), .pin(count_input_zero));
	mct_pin_src src1 (.clk(clk), .pin(count_input_one));

	// Ready signals stay high, so each response is taken at the edge it is seen.
	task automatic wr(input logic [7:0] i, input logic [7:0] v, input logic [3:0] st,
		input logic [1:0] er);
		s_axi_awaddr <= {ADDR_TOP, i, 2'h0};
		s_axi_wdata <= {24'h0, v};
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		`CHK(s_axi_bresp, er)
	endtask : wr

	task automatic rd(input logic [7:0] i, output logic [31:0] q);
		s_axi_araddr <= {ADDR_TOP, i, 2'h0};
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		q = s_axi_rdata;
		rr = s_axi_rresp;
	endtask : rd

	// A range is accepted because the divider phase at the run write is free.
	task automatic rc(input logic [7:0] i, input logic [7:0] lo, input logic [7:0] hi);
		logic [31:0] q;
		rd(i, q);
		`CHK(q, ((q >= lo) && (q <= hi)) === 1'b1 ? q : {24'h0, lo})
	endtask : rc

	task automatic span(input logic [7:0] r, input int n);
		wr(IDX_RUN, r, 4'h1, RESP_OKAY);
		repeat (n) @(posedge clk);
		wr(IDX_RUN, 8'h00, 4'h1, RESP_OKAY);
	endtask : span

	task automatic results;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results

	// Main sequence of scenarios.
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rc(IDX_MODE, 8'h00, 8'h00);
		rc(IDX_CLOCK, 8'h00, 8'h00);
		rd(8'hFF, d);
		`CHK({rr, d}, {RESP_SLVERR, 32'h0})
		wr(8'hFF, 8'h11, 4'h1, RESP_SLVERR);
		wr(IDX_MODE, 8'hA5, 4'h1, RESP_OKAY);
		wr(IDX_MODE, 8'h5A, 4'h0, RESP_OKAY);
		rc(IDX_MODE, 8'hA5, 8'hA5);
		wr(IDX_MODE, 8'h01, 4'h1, RESP_OKAY);
		// Pass 0 slow default, pass 1 fast by select, pass 2 fast by fuse.
		for (k = 0; k < 3; k++) begin
			fast_clock_fuse <= (k == 2);
			wr(IDX_U0_LO, 8'h00, 4'h1, RESP_OKAY);
			wr(IDX_CLOCK, {7'h0, k == 1}, 4'h1, RESP_OKAY);
			span(8'h01, 240);
			rc(IDX_U0_LO, k ? 8'h28 : 8'h14, k ? 8'h29 : 8'h15);
			rc(IDX_CLOCK, {6'h0, k != 0, k == 1}, {6'h0, k != 0, k == 1});
		end
		// Gated timer waits for the interrupt pin.
		fast_clock_fuse <= 1'b0;
		wr(IDX_CLOCK, 8'h00, 4'h1, RESP_OKAY);
		wr(IDX_U0_LO, 8'h00, 4'h1, RESP_OKAY);
		wr(IDX_MODE, 8'h09, 4'h1, RESP_OKAY);
		span(8'h01, 240);
		rc(IDX_U0_LO, 8'h00, 8'h00);
		external_interrupt_zero <= 1'b1;
		span(8'h01, 240);
		rc(IDX_U0_LO, 8'h14, 8'h15);
		// Gated unit 1 ignores pin falls until its gate pin rises.
		// The last three falls use the shortest advised level.
		wr(IDX_MODE, 8'hD0, 4'h1, RESP_OKAY);
		wr(IDX_RUN, 8'h02, 4'h1, RESP_OKAY);
		src1.falls(2, 24);
		repeat (24) @(posedge clk);
		rc(IDX_U1_LO, 8'h00, 8'h00);
		external_interrupt_one <= 1'b1;
		src1.falls(5, 24);
		src1.falls(3, 12);
		repeat (48) @(posedge clk);
		wr(IDX_RUN, 8'h00, 4'h1, RESP_OKAY);
		rc(IDX_U1_LO, 8'h08, 8'h08);
		// Reloading byte with unmasked overflow interrupt.
		wr(IDX_MODE, 8'h02, 4'h1, RESP_OKAY);
		wr(IDX_U0_HI, 8'hF0, 4'h1, RESP_OKAY);
		wr(IDX_U0_LO, 8'hF0, 4'h1, RESP_OKAY);
		wr(IDX_MASK, 8'h01, 4'h1, RESP_OKAY);
		span(8'h01, 300);
		rc(IDX_U0_LO, 8'hF9, 8'hFA);
		rc(IDX_U0_HI, 8'hF0, 8'hF0);
		`CHK(irq, 1'b1)
		rc(IDX_STAT, 8'h01, 8'h01);
		rc(IDX_STAT, 8'h00, 8'h00);
		`CHK(irq, 1'b0)
		// Thirteen-bit wrap with the interrupt masked.
		wr(IDX_MASK, 8'h00, 4'h1, RESP_OKAY);
		wr(IDX_MODE, 8'h00, 4'h1, RESP_OKAY);
		wr(IDX_U0_HI, 8'hFF, 4'h1, RESP_OKAY);
		wr(IDX_U0_LO, 8'h1F, 4'h1, RESP_OKAY);
		span(8'h01, 36);
		rc(IDX_U0_HI, 8'h00, 8'h00);
		rc(IDX_U0_LO, 8'h02, 8'h03);
		`CHK(irq, 1'b0)
		rc(IDX_STAT, 8'h01, 8'h01);
		// Split unit 0 while unit 1 holds; the high byte wraps and raises flag 1.
		wr(IDX_U0_LO, 8'h00, 4'h1, RESP_OKAY);
		wr(IDX_U0_HI, 8'hF0, 4'h1, RESP_OKAY);
		wr(IDX_MASK, 8'h02, 4'h1, RESP_OKAY);
		wr(IDX_MODE, 8'h33, 4'h1, RESP_OKAY);
		span(8'h03, 240);
		rc(IDX_U0_HI, 8'h04, 8'h05);
		rc(IDX_U0_LO, 8'h14, 8'h15);
		rc(IDX_U1_LO, 8'h08, 8'h08);
		`CHK(irq, 1'b1)
		rc(IDX_STAT, 8'h02, 8'h02);
		`CHK(irq, 1'b0)
		results();
	end

	// The scenarios need about 2400 cycles; this limit is some ten times that.
	initial begin
		#1000000;
		failures++;
		results();
	end
endmodule : tb_top
